// [logic/svc_pkg.sv]
// setup validity checker: shared field encodings and error codes
// assumes every setup field arrives as a plain synchronous level
package svc_pkg;
  // ----------------------------------------------------------------
  // field widths
  // ----------------------------------------------------------------
  localparam int PV_SRC_W = 2;
  localparam int SP_SRC_W = 3;
  localparam int ALM_FN_W = 4;
  localparam int SECOND_OUTPUT_FUNCTION_FN_W = 2;
  localparam int ERR_W = 3;
  localparam int QUICK_W = 5;
  localparam int QUICK_COUNT = 18;

  // ----------------------------------------------------------------
  // process value source encodings
  // ----------------------------------------------------------------
  localparam logic [PV_SRC_W-1:0] PV_INPUT_ONE = 2'h0;
  localparam logic [PV_SRC_W-1:0] PV_INPUT_TWO = 2'h1;
  localparam logic [PV_SRC_W-1:0] PV_ONE_MINUS_TWO = 2'h2;
  localparam logic [PV_SRC_W-1:0] PV_TWO_MINUS_ONE = 2'h3;

  // ----------------------------------------------------------------
  // set point source encodings
  // ----------------------------------------------------------------
  localparam logic [SP_SRC_W-1:0] SP_SETPOINT = 3'h0;
  localparam logic [SP_SRC_W-1:0] SP_MINUTE_RAMP = 3'h1;
  localparam logic [SP_SRC_W-1:0] SP_HOUR_RAMP = 3'h2;
  localparam logic [SP_SRC_W-1:0] SP_INPUT_ONE = 3'h3;
  localparam logic [SP_SRC_W-1:0] SP_INPUT_TWO = 3'h4;
  localparam logic [SP_SRC_W-1:0] SP_PUMP = 3'h5;

  // ----------------------------------------------------------------
  // alarm function encodings
  // ----------------------------------------------------------------
  localparam logic [ALM_FN_W-1:0] ALM_NONE = 4'h0;
  localparam logic [ALM_FN_W-1:0] ALM_DWELL_TIMER = 4'h1;
  localparam logic [ALM_FN_W-1:0] ALM_COMBINED_FIRST = 4'hA;
  localparam logic [ALM_FN_W-1:0] ALM_COMBINED_LAST = 4'hD;

  // ----------------------------------------------------------------
  // second output function encodings
  // ----------------------------------------------------------------
  localparam logic [SECOND_OUTPUT_FUNCTION_FN_W-1:0] SECOND_OUTPUT_FUNCTION_NONE = 2'h0;
  localparam logic [SECOND_OUTPUT_FUNCTION_FN_W-1:0] SECOND_OUTPUT_FUNCTION_COOLING = 2'h1;
  localparam logic [SECOND_OUTPUT_FUNCTION_FN_W-1:0] SECOND_OUTPUT_FUNCTION_ALARM_TWO = 2'h2;
  localparam logic [SECOND_OUTPUT_FUNCTION_FN_W-1:0] SECOND_OUTPUT_FUNCTION_DC_SUPPLY = 2'h3;

  // ----------------------------------------------------------------
  // error codes and reset values
  // ----------------------------------------------------------------
  localparam logic [ERR_W-1:0] ERR_NONE = 3'h0;
  localparam logic [ERR_W-1:0] ERR_PV_SP_ONE = 3'h1;
  localparam logic [ERR_W-1:0] ERR_PV_SP_TWO = 3'h2;
  localparam logic [ERR_W-1:0] ERR_DEPENDENT = 3'h3;
  localparam logic [ERR_W-1:0] ERR_COOLING = 3'h4;
  localparam logic [ERR_W-1:0] ERR_UNIT_MISMATCH = 3'h5;
  localparam logic [ERR_W-1:0] ERR_ALARM_NONE = 3'h6;
  localparam logic [ERR_W-1:0] ERR_DWELL_BOTH = 3'h7;
  localparam logic [QUICK_W-1:0] QUICK_NONE = 5'h00;
endpackage : svc_pkg

// [logic/svc_quick_decode.sv]
// setup validity checker: one quick-access selector decoder
// assumes the selector is a synchronous level; output is combinational
`timescale 1ns/1ns
module svc_quick_decode (
  // selector field
  input wire logic [svc_pkg::QUICK_W-1:0] quickSelect,
  // decoded result
  output logic [svc_pkg::QUICK_COUNT-1:0] promote,
  output logic outOfRange
);
  // value n in 1..18 lights bit n-1, zero lights none
  always_comb begin
    promote = '0;
    outOfRange = 1'b0;
    if (quickSelect > svc_pkg::QUICK_W'(svc_pkg::QUICK_COUNT)) begin
      outOfRange = 1'b1;
    end else if (quickSelect != svc_pkg::QUICK_NONE) begin
      promote[quickSelect - 5'h01] = 1'b1;
    end
  end
endmodule : svc_quick_decode

// [logic/svc_setup_validity_checker.sv]
// setup validity checker: flags illegal setup combinations by error code
// assumes all setup fields are held steady by the parameter store
`timescale 1ns/1ns
// Notes on behaviour
// - quick selectors: 0 none, 1-18 promote one
// - reload selector 0 loads set A, 1 set B
// - both sources input one give error 1
// - both sources input two give error 2
// - difference PV with input setpoint gives 3
// - cooling second_output_function without reverse PID gives 4
// - unit/decimal mismatch with mixed use gives 5
// - second_output_function alarm without alarm function gives 6
// - dwell timer on both alarms gives 7
// - PV source codes: one, two, differences
// - setpoint source codes: sp, ramps, inputs, pump
// - alarm 1 dwell, 10-13 combined inputs
// - second_output_function codes: 0 none, 1 cooling
module svc_setup_validity_checker #(
  parameter int NUM_SEL = 5,
  parameter int TUNE_W = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // source selection
  input wire logic [svc_pkg::PV_SRC_W-1:0] processValueSource,
  input wire logic [svc_pkg::SP_SRC_W-1:0] setpointSource,
  // output setup
  input wire logic firstOutputDirect,
  input wire logic [svc_pkg::SECOND_OUTPUT_FUNCTION_FN_W-1:0] secondOutputFunction,
  input wire logic [TUNE_W-1:0] propBandOne,
  input wire logic [TUNE_W-1:0] propBandTwo,
  input wire logic [TUNE_W-1:0] integralTimeOne,
  input wire logic [TUNE_W-1:0] integralTimeTwo,
  // input scaling
  input wire logic [1:0] inputOneUnit,
  input wire logic [1:0] inputTwoUnit,
  input wire logic [1:0] inputOneDecimals,
  input wire logic [1:0] inputTwoDecimals,
  // alarm setup
  input wire logic [svc_pkg::ALM_FN_W-1:0] alarmOneFunction,
  input wire logic [svc_pkg::ALM_FN_W-1:0] alarmTwoFunction,
  // quick-access selectors, first in the low bits
  input wire logic [NUM_SEL*svc_pkg::QUICK_W-1:0] quickSelect,
  // default reload
  input wire logic defaultSetSelect,
  input wire logic reloadRequest,
  // results
  output logic [svc_pkg::ERR_W-1:0] setupErrorCode,
  output logic setupError,
  output logic secondOutputAlarmEnable,
  output logic [NUM_SEL*svc_pkg::QUICK_COUNT-1:0] quickPromote,
  output logic [NUM_SEL-1:0] quickOutOfRange,
  output logic loadDefaultSetA,
  output logic loadDefaultSetB
);
  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (NUM_SEL < 1 || NUM_SEL > 16) begin : g_bad_sel
    $error("NUM_SEL must lie between 1 and 16");
  end
  if (TUNE_W < 1) begin : g_bad_tune
    $error("TUNE_W must be at least 1");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [svc_pkg::ERR_W-1:0] errCode;
    logic errFlag;
    logic out2Alarm;
    logic [NUM_SEL*svc_pkg::QUICK_COUNT-1:0] promote;
    logic [NUM_SEL-1:0] outOfRange;
    logic loadA;
    logic loadB;
  } svc_state_t;

  svc_state_t state_q;
  svc_state_t state_d;
  logic [NUM_SEL*svc_pkg::QUICK_COUNT-1:0] promoteDec;
  logic [NUM_SEL-1:0] rangeDec;
  logic pvIsDiff;
  logic spIsInput;
  logic pidMissing;
  logic scaleMismatch;
  logic alarmCombined;
  logic [7:1] fault;

  // ----------------------------------------------------------------
  // quick-access decoders
  // ----------------------------------------------------------------
  for (genvar i = 0; i < NUM_SEL; i++) begin : g_quick
    svc_quick_decode u_decode (
      .quickSelect(quickSelect[i*svc_pkg::QUICK_W +: svc_pkg::QUICK_W]),
      .promote(promoteDec[i*svc_pkg::QUICK_COUNT +: svc_pkg::QUICK_COUNT]),
      .outOfRange(rangeDec[i])
    );
  end

  // ----------------------------------------------------------------
  // condition terms
  // ----------------------------------------------------------------
  // source classes
  assign pvIsDiff = (processValueSource == svc_pkg::PV_ONE_MINUS_TWO) ||
                    (processValueSource == svc_pkg::PV_TWO_MINUS_ONE);
  assign spIsInput = (setpointSource == svc_pkg::SP_INPUT_ONE) ||
                     (setpointSource == svc_pkg::SP_INPUT_TWO);
  // any zero band or integral time means on-off, not PID
  assign pidMissing = (propBandOne == '0) || (propBandTwo == '0) ||
                      (integralTimeOne == '0) || (integralTimeTwo == '0);
  assign scaleMismatch = (inputOneUnit != inputTwoUnit) ||
                         (inputOneDecimals != inputTwoDecimals);
  // combined or difference alarm on either channel
  assign alarmCombined =
      (alarmOneFunction >= svc_pkg::ALM_COMBINED_FIRST &&
       alarmOneFunction <= svc_pkg::ALM_COMBINED_LAST) ||
      (alarmTwoFunction >= svc_pkg::ALM_COMBINED_FIRST &&
       alarmTwoFunction <= svc_pkg::ALM_COMBINED_LAST);

  // one flag per illegal combination, indexed by its error code
  always_comb begin
    fault[1] = (processValueSource == svc_pkg::PV_INPUT_ONE) &&
               (setpointSource == svc_pkg::SP_INPUT_ONE);
    fault[2] = (processValueSource == svc_pkg::PV_INPUT_TWO) &&
               (setpointSource == svc_pkg::SP_INPUT_TWO);
    fault[3] = pvIsDiff && spIsInput;
    fault[4] = (secondOutputFunction == svc_pkg::SECOND_OUTPUT_FUNCTION_COOLING) &&
               (firstOutputDirect || pidMissing);
    fault[5] = scaleMismatch && (pvIsDiff || spIsInput || alarmCombined);
    fault[6] = (secondOutputFunction == svc_pkg::SECOND_OUTPUT_FUNCTION_ALARM_TWO) &&
               (alarmTwoFunction == svc_pkg::ALM_NONE);
    fault[7] = (alarmOneFunction == svc_pkg::ALM_DWELL_TIMER) &&
               (alarmTwoFunction == svc_pkg::ALM_DWELL_TIMER);
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // lowest applicable code wins; evaluated every cycle so changes show
  always_comb begin
    state_d = state_q;
    state_d.errCode = svc_pkg::ERR_NONE;
    for (int c = 7; c >= 1; c--) begin
      if (fault[c]) begin
        state_d.errCode = svc_pkg::ERR_W'(c);
      end
    end
    state_d.errFlag = |fault;
    // alarm output only acts when alarm two has a function
    state_d.out2Alarm = (secondOutputFunction == svc_pkg::SECOND_OUTPUT_FUNCTION_ALARM_TWO) &&
                        (alarmTwoFunction != svc_pkg::ALM_NONE);
    state_d.promote = promoteDec;
    state_d.outOfRange = rangeDec;
    // reload pulses follow the request by one cycle
    state_d.loadA = reloadRequest && !defaultSetSelect;
    state_d.loadB = reloadRequest && defaultSetSelect;
  end

  // state register
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign setupErrorCode = state_q.errCode;
  assign setupError = state_q.errFlag;
  assign secondOutputAlarmEnable = state_q.out2Alarm;
  assign quickPromote = state_q.promote;
  assign quickOutOfRange = state_q.outOfRange;
  assign loadDefaultSetA = state_q.loadA;
  assign loadDefaultSetB = state_q.loadB;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  a_err_pv_one: assert property (
    (processValueSource == svc_pkg::PV_INPUT_ONE &&
     setpointSource == svc_pkg::SP_INPUT_ONE) |=> setupErrorCode == 3'h1)
    else $error("input one on both sources did not give code 1");
  a_err_pv_two: assert property (
    (processValueSource == svc_pkg::PV_INPUT_TWO &&
     setpointSource == svc_pkg::SP_INPUT_TWO) |=> setupErrorCode == 3'h2)
    else $error("input two on both sources did not give code 2");
  a_err_dependent: assert property (
    (processValueSource[1] && spIsInput) |=> setupErrorCode == 3'h3)
    else $error("difference with input set point did not give code 3");
  a_err_cooling: assert property (
    (!fault[1] && !fault[2] && !fault[3] &&
     secondOutputFunction == svc_pkg::SECOND_OUTPUT_FUNCTION_COOLING &&
     (firstOutputDirect || integralTimeOne == '0)) |=> setupErrorCode == 3'h4)
    else $error("bad cooling setup did not give code 4");
  a_err_scale: assert property (
    (fault[5] && !(|fault[4:1])) |=> setupErrorCode == 3'h5)
    else $error("scale mismatch did not give code 5");
  a_alarm_gate: assert property (
    (alarmTwoFunction == svc_pkg::ALM_NONE) |=> !secondOutputAlarmEnable)
    else $error("second output alarm enabled with no alarm function");
  a_err_dwell: assert property (
    (fault[7] && !(|fault[6:1])) |=> setupErrorCode == 3'h7)
    else $error("dwell on both alarms did not give code 7");
  a_err_clear: assert property (
    (fault == 7'h00) |=> (setupErrorCode == 3'h0 && !setupError))
    else $error("error reported with a legal setup");
  a_reload_pair: assert property (
    reloadRequest |=> (loadDefaultSetA != loadDefaultSetB) &&
                      (loadDefaultSetB == $past(defaultSetSelect)))
    else $error("reload pulse went to the wrong default set");
  a_quick_none: assert property (
    (quickSelect[svc_pkg::QUICK_W-1:0] == 5'h00) |=>
      quickPromote[svc_pkg::QUICK_COUNT-1:0] == '0)
    else $error("zero selector promoted a parameter");

  c_err_cooling: cover property (setupErrorCode == 3'h4);
  c_err_dwell: cover property (setupErrorCode == 3'h7);
  c_err_change: cover property (setupError ##1 !setupError);
  c_reload_b: cover property (loadDefaultSetB);
endmodule : svc_setup_validity_checker

// [verif/tb.sv]
// testbench for the setup validity checker: drives every setup field by hand
// assumes results appear just after the sampling rising edge, as registered levels, read at the next falling edge
`timescale 1ns/1ns
module tb;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic clk_sys, reset_n, firstOutputDirect, defaultSetSelect, reloadRequest;
  logic [1:0] processValueSource, secondOutputFunction;
  logic [2:0] setpointSource;
  logic [15:0] propBandOne, propBandTwo, integralTimeOne, integralTimeTwo;
  logic [1:0] inputOneUnit, inputTwoUnit, inputOneDecimals, inputTwoDecimals;
  logic [3:0] alarmOneFunction, alarmTwoFunction;
  logic [24:0] quickSelect;
  logic [2:0] setupErrorCode;
  logic setupError, secondOutputAlarmEnable, loadDefaultSetA, loadDefaultSetB;
  logic [89:0] quickPromote;
  logic [4:0] quickOutOfRange;
  int err_total = 0;
  int checked = 0;

  svc_setup_validity_checker svc_setup_validity_checker_inst (
    .clk_sys(clk_sys), .reset_n(reset_n),
    .processValueSource(processValueSource), .setpointSource(setpointSource),
    .firstOutputDirect(firstOutputDirect), .secondOutputFunction(secondOutputFunction),
    .propBandOne(propBandOne), .propBandTwo(propBandTwo),
    .integralTimeOne(integralTimeOne), .integralTimeTwo(integralTimeTwo),
    .inputOneUnit(inputOneUnit), .inputTwoUnit(inputTwoUnit),
    .inputOneDecimals(inputOneDecimals), .inputTwoDecimals(inputTwoDecimals),
    .alarmOneFunction(alarmOneFunction), .alarmTwoFunction(alarmTwoFunction),
    .quickSelect(quickSelect), .defaultSetSelect(defaultSetSelect),
    .reloadRequest(reloadRequest), .setupErrorCode(setupErrorCode),
    .setupError(setupError), .secondOutputAlarmEnable(secondOutputAlarmEnable),
    .quickPromote(quickPromote), .quickOutOfRange(quickOutOfRange),
    .loadDefaultSetA(loadDefaultSetA), .loadDefaultSetB(loadDefaultSetB)
  );

  // ----------------------------------------------------------------
  // clock, comparison and closing helpers
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [89:0] seen, input logic [89:0] exp, input string msg);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test

  // one legal-or-not setup applied at a falling edge, code judged a cycle later
  task automatic run_case(input logic [1:0] pv, input logic [2:0] sp, input logic dir,
                          input logic [1:0] o2, input logic pbZero, input logic [3:0] a1,
                          input logic [3:0] a2, input logic [1:0] mis, input logic [2:0] exp);
    processValueSource = pv;
    setpointSource = sp;
    firstOutputDirect = dir;
    secondOutputFunction = o2;
    propBandOne = pbZero ? 16'h0000 : 16'h0010;
    alarmOneFunction = a1;
    alarmTwoFunction = a2;
    inputTwoUnit = inputOneUnit ^ {1'b0, mis[0]};
    inputTwoDecimals = inputOneDecimals ^ {1'b0, mis[1]};
    @(posedge clk_sys);
    @(negedge clk_sys);
    check(setupErrorCode, exp, "error code");
    check(setupError, exp != 3'h0, "error flag");
  endtask : run_case

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic test_sources();
    run_case(2'h0, 3'h3, 0, 2'h0, 0, 4'h0, 4'h0, 2'h0, 3'h1);
    run_case(2'h1, 3'h4, 0, 2'h0, 0, 4'h0, 4'h0, 2'h0, 3'h2);
    run_case(2'h2, 3'h3, 0, 2'h0, 0, 4'h0, 4'h0, 2'h0, 3'h3);
    run_case(2'h3, 3'h4, 0, 2'h0, 0, 4'h0, 4'h0, 2'h0, 3'h3);
    run_case(2'h3, 3'h5, 0, 2'h0, 0, 4'h0, 4'h0, 2'h0, 3'h0);
    $display("sources done");
  endtask : test_sources

  task automatic test_outputs();
    run_case(2'h0, 3'h0, 1, 2'h1, 0, 4'h0, 4'h0, 2'h0, 3'h4);
    run_case(2'h0, 3'h0, 0, 2'h1, 1, 4'h0, 4'h0, 2'h0, 3'h4);
    run_case(2'h0, 3'h0, 1, 2'h0, 1, 4'h0, 4'h0, 2'h0, 3'h0);
    run_case(2'h0, 3'h0, 0, 2'h2, 0, 4'h0, 4'h0, 2'h0, 3'h6);
    check(secondOutputAlarmEnable, 1'b0, "alarm out off");
    run_case(2'h0, 3'h0, 0, 2'h2, 0, 4'h0, 4'h2, 2'h0, 3'h0);
    check(secondOutputAlarmEnable, 1'b1, "alarm out on");
    run_case(2'h0, 3'h0, 0, 2'h0, 0, 4'h1, 4'h1, 2'h0, 3'h7);
    run_case(2'h0, 3'h0, 0, 2'h0, 0, 4'h1, 4'h0, 2'h0, 3'h0);
    run_case(2'h0, 3'h0, 0, 2'h3, 0, 4'h0, 4'h0, 2'h0, 3'h0);
    check(secondOutputAlarmEnable, 1'b0, "supply code no alarm");
    $display("outputs done");
  endtask : test_outputs

  task automatic test_scaling();
    run_case(2'h2, 3'h0, 0, 2'h0, 0, 4'h0, 4'h0, 2'h1, 3'h5);
    run_case(2'h0, 3'h0, 0, 2'h0, 0, 4'hD, 4'h0, 2'h2, 3'h5);
    run_case(2'h0, 3'h0, 0, 2'h0, 0, 4'h0, 4'hA, 2'h1, 3'h5);
    run_case(2'h0, 3'h0, 0, 2'h0, 0, 4'h9, 4'hE, 2'h3, 3'h0);
    run_case(2'h1, 3'h3, 0, 2'h0, 0, 4'h0, 4'h0, 2'h1, 3'h5);
    run_case(2'h0, 3'h1, 0, 2'h0, 0, 4'h0, 4'h0, 2'h3, 3'h0);
    run_case(2'h0, 3'h2, 0, 2'h0, 0, 4'h0, 4'h0, 2'h3, 3'h0);
    $display("scaling done");
  endtask : test_scaling

  task automatic test_priority();
    run_case(2'h0, 3'h3, 1, 2'h1, 0, 4'h1, 4'h1, 2'h0, 3'h1);
    run_case(2'h2, 3'h4, 0, 2'h2, 0, 4'h1, 4'h0, 2'h1, 3'h3);
    run_case(2'h2, 3'h0, 0, 2'h2, 0, 4'h1, 4'h1, 2'h1, 3'h5);
    $display("priority done");
  endtask : test_priority

  task automatic test_quick();
    logic [89:0] exp;
    quickSelect = {5'h13, 5'h12, 5'h0A, 5'h01, 5'h00};
    exp = '0;
    exp[18] = 1'b1;
    exp[45] = 1'b1;
    exp[71] = 1'b1;
    @(posedge clk_sys);
    @(negedge clk_sys);
    check(quickPromote, exp, "promote mix");
    check(quickOutOfRange, 5'h10, "range mix");
    quickSelect = {5'h02, 5'h1F, 5'h12, 5'h00, 5'h01};
    exp = '0;
    exp[0] = 1'b1;
    exp[53] = 1'b1;
    exp[73] = 1'b1;
    @(posedge clk_sys);
    @(negedge clk_sys);
    check(quickPromote, exp, "promote swap");
    check(quickOutOfRange, 5'h08, "range swap");
    $display("quick done");
  endtask : test_quick

  task automatic test_reload();
    defaultSetSelect = 1'b1;
    reloadRequest = 1'b1;
    repeat (2) begin
      @(posedge clk_sys);
      @(negedge clk_sys);
      check({loadDefaultSetA, loadDefaultSetB}, 2'h1, "reload set b");
    end
    defaultSetSelect = 1'b0;
    @(posedge clk_sys);
    @(negedge clk_sys);
    check({loadDefaultSetA, loadDefaultSetB}, 2'h2, "reload set a");
    reloadRequest = 1'b0;
    @(posedge clk_sys);
    @(negedge clk_sys);
    check({loadDefaultSetA, loadDefaultSetB}, 2'h0, "reload idle");
    $display("reload done");
  endtask : test_reload

  task automatic test_reset();
    run_case(2'h1, 3'h4, 0, 2'h0, 0, 4'h0, 4'h0, 2'h0, 3'h2);
    reset_n = 1'b0;
    #1;
    check({setupErrorCode, setupError}, 4'h0, "code in reset");
    @(negedge clk_sys);
    reset_n = 1'b1;
    @(posedge clk_sys);
    @(negedge clk_sys);
    check(setupErrorCode, 3'h2, "code after reset");
    $display("reset done");
  endtask : test_reset

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    reset_n = 1'b0;
    {firstOutputDirect, defaultSetSelect, reloadRequest} = 3'h0;
    {processValueSource, secondOutputFunction, setpointSource} = 7'h00;
    propBandOne = 16'h0010;
    propBandTwo = 16'h0020;
    integralTimeOne = 16'h0030;
    integralTimeTwo = 16'h0040;
    {inputOneUnit, inputTwoUnit, inputOneDecimals, inputTwoDecimals} = 8'h00;
    {alarmOneFunction, alarmTwoFunction} = 8'h00;
    quickSelect = '0;
    repeat (5) @(posedge clk_sys);
    @(negedge clk_sys);
    reset_n = 1'b1;
    test_sources();
    test_outputs();
    test_scaling();
    test_priority();
    test_quick();
    test_reload();
    test_reset();
    finish_test();
  end

  // cut a hang well past the roughly forty cycles the scenarios need
  initial begin
    #20000;
    err_total++;
    finish_test();
  end
endmodule : tb
